// [rtl/hcb_pkg.sv]
// Shared constants and types for the hard-copy I/O bus front end
package hcb_pkg;
  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int DATA_W   = 36;
  localparam int SEL_W    = 7;
  localparam int PI_W     = 7;
  localparam int NUM_SUB  = 4;
  // ****************************************************************
  // Default select codes
  // ****************************************************************
  // default wiring option codes
  localparam logic [6:0] CODE_PUNCH   = 7'o110;
  localparam logic [6:0] CODE_READER  = 7'o150;
  localparam logic [6:0] CODE_PRINTER = 7'o124;
  localparam logic [6:0] CODE_PLOTTER = 7'o140;
  // ****************************************************************
  // Control word layout and reset values
  // ****************************************************************
  localparam int          CTL_W       = 12;
  localparam int          CTL_LSB     = 0;
  localparam int          PI_LVL_LSB  = 0;
  localparam int          IRQ_EN_BIT  = 3;
  localparam logic [11:0] CTL_RST     = 12'h000;
  localparam logic [35:0] DATA_RST    = 36'h000000000;
  localparam logic [6:0]  PI_NONE     = 7'h00;
  // Host sequencer states
  typedef enum logic [2:0] {
    HCB_IDLE  = 3'b000,
    HCB_CLR   = 3'b001,
    HCB_SET   = 3'b011,
    HCB_GATE  = 3'b010,
    HCB_DONE  = 3'b110
  } hcb_host_state_t;
  // Instruction kinds
  typedef enum logic [1:0] {
    HCB_CONDITIONS_OUT_INSTR = 2'h0,
    HCB_CONDITIONS_IN_INSTR = 2'h1,
    HCB_DATO = 2'h2,
    HCB_DATI = 2'h3
  } hcb_op_t;
  // Decode of complementary select pairs against a code
  function automatic logic hcb_match(input logic [6:0] t, input logic [6:0] f,
                                     input logic [6:0] code);
    hcb_match = ((t & code) == code) && ((f & ~code) == ~code);
  endfunction : hcb_match
endpackage : hcb_pkg

// [rtl/hcb_bus_if.sv]
// I/O bus carrier between the processor end and the controller end
`timescale 1ns/1ps
interface hcb_bus_if;
  logic [6:0]  sel_true;          // Select lines, true polarity
  logic [6:0]  sel_comp;          // Select lines, complement polarity
  logic        bus_initialize;    // Bus reset level
  logic        conditions_out_clear;
  logic        conditions_out_load;
  logic        conditions_in_gate;
  logic        data_out_clear;
  logic        data_out_load;
  logic        data_in_gate;
  logic        hardware_readin_pulse;
  logic [35:0] host_data_o;       // Processor drive
  logic        host_data_oe_n;    // Processor enable, low drives
  logic [35:0] dev_data_o;        // Controller drive
  logic        dev_data_oe_n;     // Controller enable, low drives
  logic [6:0]  priority_request_levels; // Open-drain requests, high means asserted
  logic        readin_data_ready;
  wire  [35:0] io_data_lines;     // Resolved bus word
  // Resolve the wired bus: undriven reads zero
  assign io_data_lines = !host_data_oe_n ? host_data_o :
                         (!dev_data_oe_n ? dev_data_o : 36'h000000000);
  modport host (
    output sel_true, sel_comp, bus_initialize, conditions_out_clear,
           conditions_out_load, conditions_in_gate, data_out_clear,
           data_out_load, data_in_gate, hardware_readin_pulse,
           host_data_o, host_data_oe_n,
    input  io_data_lines, priority_request_levels, readin_data_ready
  );
  modport dev (
    input  sel_true, sel_comp, bus_initialize, conditions_out_clear,
           conditions_out_load, conditions_in_gate, data_out_clear,
           data_out_load, data_in_gate, hardware_readin_pulse, io_data_lines,
    output dev_data_o, dev_data_oe_n, priority_request_levels, readin_data_ready
  );
endinterface : hcb_bus_if

// [rtl/hcb_host.sv]
// Processor end: issues one I/O instruction per request on the bus
`timescale 1ns/1ps
module hcb_host (
  input  wire logic                core_clk,   // System clock
  input  wire logic                rst,        // Synchronous reset, high
  hcb_bus_if.host                  bus,        // I/O bus
  input  wire logic                req_valid,  // Start an instruction
  input  wire logic [1:0]          req_op,     // hcb_op_t kind
  input  wire logic [6:0]          req_code,   // Device select code
  input  wire logic [35:0]         req_data,   // Word for out instructions
  input  wire logic                init_req,   // Pulse the bus initialize
  output logic                     req_ready,  // Idle, may accept
  output logic                     rsp_valid,  // Read word valid
  output logic [35:0]              rsp_data,   // Word read back
  output logic [6:0]               pi_seen     // Synchronised request levels
);
  hcb_pkg::hcb_host_state_t st_reg, st_next;
  logic [1:0]  op_reg, op_next;
  logic [6:0]  code_reg, code_next;
  logic [35:0] wd_reg, wd_next;
  logic        init_reg, init_next;
  logic        rv_reg, rv_next;
  logic [35:0] rd_reg, rd_next;
  logic        ready_reg, ready_next;
  logic        is_out;
  assign is_out = (op_reg == hcb_pkg::HCB_CONDITIONS_OUT_INSTR) || (op_reg == hcb_pkg::HCB_DATO);
  // ****************************************************************
  // Sequencer: select, clear, load or gate, done
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    code_next = code_reg;
    wd_next = wd_reg;
    init_next = init_req;
    rv_next = 1'b0;
    rd_next = rd_reg;
    case (st_reg)
      hcb_pkg::HCB_IDLE: begin
        if (req_valid && !init_req) begin
          op_next = req_op;
          code_next = req_code;
          wd_next = req_data;
          st_next = ((req_op == hcb_pkg::HCB_CONDITIONS_OUT_INSTR) || (req_op == hcb_pkg::HCB_DATO))
                    ? hcb_pkg::HCB_CLR : hcb_pkg::HCB_GATE;
        end
      end
      hcb_pkg::HCB_CLR:  st_next = hcb_pkg::HCB_SET;
      hcb_pkg::HCB_SET:  st_next = hcb_pkg::HCB_DONE;
      hcb_pkg::HCB_GATE: st_next = hcb_pkg::HCB_DONE;
      hcb_pkg::HCB_DONE: begin
        // Controller drive is registered: take the word one cycle after the gate
        if (!is_out) begin
          rv_next = 1'b1;
          rd_next = bus.io_data_lines;
        end
        st_next = hcb_pkg::HCB_IDLE;
      end
      default:           st_next = hcb_pkg::HCB_IDLE;
    endcase
    ready_next = (st_next == hcb_pkg::HCB_IDLE) && !init_next;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg   <= hcb_pkg::HCB_IDLE;
      op_reg   <= hcb_pkg::HCB_CONDITIONS_OUT_INSTR;
      code_reg <= 7'h00;
      wd_reg   <= hcb_pkg::DATA_RST;
      init_reg <= 1'b0;
      rv_reg   <= 1'b0;
      rd_reg   <= hcb_pkg::DATA_RST;
      ready_reg <= 1'b1;
    end else begin
      st_reg   <= st_next;
      op_reg   <= op_next;
      code_reg <= code_next;
      wd_reg   <= wd_next;
      init_reg <= init_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      ready_reg <= ready_next;
    end
  end
  // Request levels come from logic on this clock: one register only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pi_seen <= hcb_pkg::PI_NONE;
    end else begin
      pi_seen <= bus.priority_request_levels;
    end
  end
  // ****************************************************************
  // Bus drive
  // ****************************************************************
  wire active = (st_reg != hcb_pkg::HCB_IDLE);
  assign bus.sel_true  = active ? code_reg : 7'h00;
  assign bus.sel_comp  = active ? ~code_reg : 7'h00;
  assign bus.bus_initialize = init_reg;
  assign bus.conditions_out_clear = (st_reg == hcb_pkg::HCB_CLR) && (op_reg == hcb_pkg::HCB_CONDITIONS_OUT_INSTR);
  assign bus.conditions_out_load  = (st_reg == hcb_pkg::HCB_SET) && (op_reg == hcb_pkg::HCB_CONDITIONS_OUT_INSTR);
  assign bus.data_out_clear = (st_reg == hcb_pkg::HCB_CLR) && (op_reg == hcb_pkg::HCB_DATO);
  assign bus.data_out_load  = (st_reg == hcb_pkg::HCB_SET) && (op_reg == hcb_pkg::HCB_DATO);
  assign bus.conditions_in_gate = (st_reg == hcb_pkg::HCB_GATE) && (op_reg == hcb_pkg::HCB_CONDITIONS_IN_INSTR);
  assign bus.data_in_gate = (st_reg == hcb_pkg::HCB_GATE) && (op_reg == hcb_pkg::HCB_DATI);
  assign bus.hardware_readin_pulse = 1'b0;
  // processor drives the word during out instructions
  assign bus.host_data_o    = wd_reg;
  assign bus.host_data_oe_n = !(active && is_out && (st_reg != hcb_pkg::HCB_DONE));
  assign req_ready = ready_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data  = rd_reg;
endmodule : hcb_host

// [rtl/hcb_dev.sv]
// Controller end: select decode and strobe handling for four sub-controllers
`timescale 1ns/1ps
module hcb_dev #(
  parameter logic [6:0] CODE_PUNCH   = hcb_pkg::CODE_PUNCH,   // Wiring option
  parameter logic [6:0] CODE_READER  = hcb_pkg::CODE_READER,  // Wiring option
  parameter logic [6:0] CODE_PRINTER = hcb_pkg::CODE_PRINTER, // Wiring option
  parameter logic [6:0] CODE_PLOTTER = hcb_pkg::CODE_PLOTTER  // Wiring option
) (
  input  wire logic          core_clk,    // System clock
  input  wire logic          rst,         // Synchronous reset, high
  hcb_bus_if.dev             bus,         // I/O bus
  input  wire logic [3:0]    attached,    // Peripheral present, one per sub
  input  wire logic [143:0]  status_in,   // Status words, sub 0 in low bits
  input  wire logic [3:0]    irq_event,   // Completion or error, level
  output logic [3:0]         selected,    // Registered select per sub
  output logic [47:0]        ctl_out,     // Control registers, 12 bits per sub
  output logic [143:0]       buf_out,     // Data buffers, 36 bits per sub
  output logic [3:0]         buf_loaded   // One-cycle load pulse per sub
);
  localparam int N = hcb_pkg::NUM_SUB;
  localparam logic [6:0] CODES [N] = '{CODE_PUNCH, CODE_READER, CODE_PRINTER, CODE_PLOTTER};
  // ****************************************************************
  // Receivers: punch has its own set, others share one
  // ****************************************************************
  // Bus strobes come from logic on this clock: no capture stages, so one-cycle pulses survive
  localparam int RW = 7 + 7 + 8 + 36;
  logic [RW-1:0] rx_in;
  logic [RW-1:0] ra_q, rb_q;
  assign rx_in = {bus.sel_true, bus.sel_comp, bus.bus_initialize, bus.conditions_out_clear,
                  bus.conditions_out_load, bus.conditions_in_gate, bus.data_out_clear,
                  bus.data_out_load, bus.data_in_gate, 1'b0, bus.io_data_lines};
  // two independent receiver sets: punch alone, the rest shared
  assign ra_q = rx_in;
  assign rb_q = rx_in;
  // ****************************************************************
  // Per-sub decode, registers and strobes
  // ****************************************************************
  logic [3:0]   sel_next, ld_next;
  logic [47:0]  ctl_next;
  logic [143:0] buf_next;
  logic [3:0]   prv_reg [N];
  logic [3:0]   prv_next [N];
  logic [6:0]   pi_next, pi_reg;
  logic [35:0]  drv_next, drv_reg;
  logic         oe_n_next, oe_n_reg;
  always_comb begin
    logic [RW-1:0] r;
    logic          hit, ini, cclr, cset, cin, dclr, dset, din;
    logic [6:0]    lvl;
    r = '0;
    hit = 1'b0;
    ini = 1'b0;
    cclr = 1'b0;
    cset = 1'b0;
    cin = 1'b0;
    dclr = 1'b0;
    dset = 1'b0;
    din = 1'b0;
    lvl = 7'h00;
    ctl_next = ctl_out;
    buf_next = buf_out;
    sel_next = 4'h0;
    ld_next = 4'h0;
    pi_next = hcb_pkg::PI_NONE;
    drv_next = hcb_pkg::DATA_RST;
    oe_n_next = 1'b1;
    for (int i = 0; i < N; i++) begin
      r = (i == 0) ? ra_q : rb_q;
      ini = r[43];
      // match own code only when attached
      hit = attached[i] && hcb_pkg::hcb_match(r[57:51], r[50:44], CODES[i]);
      sel_next[i] = hit;
      // Rising edges of the clear and load strobes; idle level is low
      cclr = r[42] && !prv_reg[i][2];
      cset = r[41] && !prv_reg[i][1];
      dclr = r[39] && !prv_reg[i][0];
      dset = r[38] && !prv_reg[i][3];
      cin  = r[40];
      din  = r[37];
      prv_next[i] = {r[38], r[42], r[41], r[39]};
      if (ini) begin
        ctl_next[i*12 +: 12] = hcb_pkg::CTL_RST;
        buf_next[i*36 +: 36] = hcb_pkg::DATA_RST;
      end else if (hit) begin
        if (cclr) ctl_next[i*12 +: 12] = hcb_pkg::CTL_RST;
        // load control bits from the data lines
        if (cset) ctl_next[i*12 +: 12] = r[hcb_pkg::CTL_LSB +: hcb_pkg::CTL_W];
        if (dclr) buf_next[i*36 +: 36] = hcb_pkg::DATA_RST;
        if (dset) begin
          buf_next[i*36 +: 36] = r[35:0];
          ld_next[i] = 1'b1;
        end
        if (cin) begin
          drv_next = status_in[i*36 +: 36];
          oe_n_next = 1'b0;
        end
        // data register onto bus in the cycle after the gate
        if (din) begin
          drv_next = buf_out[i*36 +: 36];
          oe_n_next = 1'b0;
        end
      end
      // request on programmed level when enabled
      lvl = 7'h01 << (ctl_out[i*12 + hcb_pkg::PI_LVL_LSB +: 3] - 3'd1);
      if (attached[i] && irq_event[i] && ctl_out[i*12 + hcb_pkg::IRQ_EN_BIT]
          && (ctl_out[i*12 + hcb_pkg::PI_LVL_LSB +: 3] != 3'd0))
        pi_next = pi_next | lvl;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      selected   <= 4'h0;
      ctl_out    <= {N{hcb_pkg::CTL_RST}};
      buf_out    <= {N{hcb_pkg::DATA_RST}};
      buf_loaded <= 4'h0;
      pi_reg     <= hcb_pkg::PI_NONE;
      drv_reg    <= hcb_pkg::DATA_RST;
      oe_n_reg   <= 1'b1;
      for (int i = 0; i < N; i++) prv_reg[i] <= 4'h0;
    end else begin
      selected   <= sel_next;
      ctl_out    <= ctl_next;
      buf_out    <= buf_next;
      buf_loaded <= ld_next;
      pi_reg     <= pi_next;
      drv_reg    <= drv_next;
      oe_n_reg   <= oe_n_next;
      for (int i = 0; i < N; i++) prv_reg[i] <= prv_next[i];
    end
  end
  // device returns words on the shared lines
  assign bus.dev_data_o    = drv_reg;
  assign bus.dev_data_oe_n = oe_n_reg;
  assign bus.priority_request_levels = pi_reg;
  assign bus.readin_data_ready = 1'b0;
endmodule : hcb_dev

// [dv/hcb_bus_checker.sv]
// Concurrent checks on the I/O bus between the processor and controller ends
`timescale 1ns/1ps
module hcb_bus_checker (
  input wire logic       core_clk,                // System clock
  input wire logic       rst,                     // Synchronous reset, high
  input wire logic [6:0] sel_true,                // Select, true polarity
  input wire logic [6:0] sel_comp,                // Select, complement polarity
  input wire logic       bus_initialize,          // Bus reset level
  input wire logic       conditions_out_clear,    // Control clear strobe
  input wire logic       conditions_out_load,     // Control load strobe
  input wire logic       conditions_in_gate,      // Status read gate
  input wire logic       data_out_clear,          // Buffer clear strobe
  input wire logic       data_out_load,           // Buffer load strobe
  input wire logic       data_in_gate,            // Data read gate
  input wire logic       host_data_oe_n,          // Host drive, low drives
  input wire logic       dev_data_oe_n,           // Controller drive, low drives
  input wire logic [6:0] priority_request_levels, // Request levels
  input wire logic       readin_data_ready        // Read-in ready
);
  logic [3:0] gate_age_reg;
  logic [3:0] gate_age_next;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles since a read gate was last high, saturating
  always_comb begin
    gate_age_next = gate_age_reg;
    if (conditions_in_gate || data_in_gate) gate_age_next = 4'h0;
    else if (gate_age_reg != 4'hf) gate_age_next = gate_age_reg + 4'h1;
  end
  always_ff @(posedge core_clk) begin
    if (rst) gate_age_reg <= 4'hf;
    else gate_age_reg <= gate_age_next;
  end
  pair_match_a: assert property ((data_out_clear || data_out_load || conditions_out_clear ||
    conditions_out_load || conditions_in_gate || data_in_gate) |-> sel_comp == ~sel_true)
    else $error("select pair not complementary");
  readin_quiet_a: assert property (readin_data_ready == 1'b0)
    else $error("read-in ready driven");
  one_driver_a: assert property (!(!host_data_oe_n && !dev_data_oe_n))
    else $error("both ends drive the data lines");
  gated_drive_a: assert property (!dev_data_oe_n |-> gate_age_reg == 4'h0)
    else $error("controller drives without a read gate");
  dato_order_a: assert property ($rose(data_out_load) |-> $past(data_out_clear))
    else $error("buffer load without prior clear");
  conditions_out_instr_order_a: assert property ($rose(conditions_out_load) |->
    $past(conditions_out_clear)) else $error("control load without prior clear");
  held_select_a: assert property ((data_out_load || conditions_out_load) |->
    $stable(sel_true)) else $error("select moved during load");
  load_drives_a: assert property ((data_out_load || conditions_out_load) |->
    !host_data_oe_n) else $error("load strobe without host drive");
  init_quiet_a: assert property (bus_initialize |->
    ##[1:10] priority_request_levels == 7'h00) else $error("requests remain after initialize");
  read_drive_c: cover property (!dev_data_oe_n);
  status_gate_c: cover property (conditions_in_gate);
  buffer_load_c: cover property ($rose(data_out_load));
  request_c: cover property (priority_request_levels != 7'h00);
endmodule : hcb_bus_checker

// [dv/io_bus_device_select_and_strobes_tb.sv]
// Self-checking bench joining the processor end to the controller end
`timescale 1ns/1ps
module io_bus_device_select_and_strobes_tb;
  logic         core_clk;
  logic         rst;
  logic         req_valid;
  logic [1:0]   req_op;
  logic [6:0]   req_code;
  logic [35:0]  req_data;
  logic         init_req;
  logic         req_ready;
  logic         rsp_valid;
  logic [35:0]  rsp_data;
  logic [6:0]   pi_seen;
  logic [3:0]   attached;
  logic [143:0] status_in;
  logic [3:0]   irq_event;
  logic [3:0]   selected;
  logic [47:0]  ctl_out;
  logic [143:0] buf_out;
  logic [3:0]   buf_loaded;
  logic [35:0]  rd;
  logic [6:0]   codes [4];
  logic [3:0]   sel_seen;
  logic [3:0]   loads_seen;
  int           bad_count;
  int           samples_checked;
  hcb_bus_if bus_if ();
  hcb_host hcb_host_i (.core_clk, .rst, .bus(bus_if), .req_valid, .req_op, .req_code,
    .req_data, .init_req, .req_ready, .rsp_valid, .rsp_data, .pi_seen);
  hcb_dev hcb_dev_i (.core_clk, .rst, .bus(bus_if), .attached, .status_in, .irq_event,
    .selected, .ctl_out, .buf_out, .buf_loaded);
  hcb_bus_checker hcb_bus_checker_i (.core_clk, .rst, .sel_true(bus_if.sel_true),
    .sel_comp(bus_if.sel_comp), .bus_initialize(bus_if.bus_initialize),
    .conditions_out_clear(bus_if.conditions_out_clear),
    .conditions_out_load(bus_if.conditions_out_load),
    .conditions_in_gate(bus_if.conditions_in_gate), .data_out_clear(bus_if.data_out_clear),
    .data_out_load(bus_if.data_out_load), .data_in_gate(bus_if.data_in_gate),
    .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
    .priority_request_levels(bus_if.priority_request_levels),
    .readin_data_ready(bus_if.readin_data_ready));
  // Free-running clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Advance n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // Current value of a buffer, control word or request view
  function automatic logic [35:0] probe(input int s);
    if (s < 4) return buf_out[s*36 +: 36];
    if (s < 8) return {24'h0, ctl_out[(s-4)*12 +: 12]};
    return {29'h0, pi_seen};
  endfunction : probe
  // Bounded wait for a value, then compare
  task automatic await(input string what, input int s, input logic [35:0] exp);
    int n;
    n = 0;
    while (probe(s) !== exp && n < 16) begin
      cyc(1);
      n++;
    end
    chk(what, exp, probe(s));
  endtask : await
  // Check that a sub-controller took no select and no load in the last instruction
  task automatic quiet(input int k);
    chk("stray select", 36'h0, {35'h0, sel_seen[k]});
    chk("stray load", 36'h0, {35'h0, loads_seen[k]});
  endtask : quiet
  // One instruction through the processor end; read word lands in rd
  task automatic issue(input logic [1:0] op, input logic [6:0] code, input logic [35:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_code = code;
    req_data = d;
    cyc(1);
    req_valid = 1'b0;
    rd = 36'h0;
    sel_seen = 4'h0;
    loads_seen = 4'h0;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      if (rsp_valid === 1'b1) rd = rsp_data;
      sel_seen = sel_seen | selected;
      loads_seen = loads_seen | buf_loaded;
      cyc(1);
      n++;
    end
    if (rsp_valid === 1'b1) rd = rsp_data;
    chk("instruction finish", 36'h1, {35'h0, req_ready});
  endtask : issue
  // Counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // Watchdog against a hang
  initial begin
    #40000;
    bad_count++;
    $display("unexpected watchdog: expected finish seen hang");
    conclude();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_code = 7'h00;
    req_data = 36'h0;
    init_req = 1'b0;
    attached = 4'hf;
    status_in = 144'h0;
    irq_event = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    codes = '{hcb_pkg::CODE_PUNCH, hcb_pkg::CODE_READER, hcb_pkg::CODE_PRINTER,
              hcb_pkg::CODE_PLOTTER};
    cyc(3);
    rst = 1'b0;
    chk("reset controller drive", 36'h1, {35'h0, bus_if.dev_data_oe_n});
    chk("reset control", 36'h0, ctl_out[35:0]);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      issue(2'h2, codes[k], {28'h5a5a5a5, 8'(k)});
      chk("own select", {32'h0, 4'h1 << k}, {32'h0, sel_seen});
      await("buffer load", k, {28'h5a5a5a5, 8'(k)});
    end
    issue(2'h2, 7'h3f, 36'hfedcba987);
    quiet(0);
    for (int k = 0; k < 4; k++) chk("buffer kept", {28'h5a5a5a5, 8'(k)}, probe(k));
    $display("select test done");
    issue(2'h2, codes[2], 36'hfffffffff);
    issue(2'h2, codes[2], 36'h000000005);
    await("buffer reload", 2, 36'h000000005);
    $display("buffer clear test done");
    issue(2'h0, codes[2], 36'h00000000b);
    await("control load", 6, 36'h00b);
    irq_event = 4'h4;
    await("request level", 8, 36'h04);
    issue(2'h0, codes[2], 36'h0);
    await("control clear", 6, 36'h0);
    await("request drop", 8, 36'h0);
    $display("control test done");
    status_in[36 +: 36] = 36'h123456789;
    issue(2'h1, codes[1], 36'h0);
    chk("status read", 36'h123456789, rd);
    issue(2'h3, codes[0], 36'h0);
    chk("data read", {28'h5a5a5a5, 8'h00}, rd);
    $display("read test done");
    attached = 4'hd;
    issue(2'h2, codes[1], 36'h0000000aa);
    quiet(1);
    issue(2'h1, codes[1], 36'h0);
    chk("absent status", 36'h0, rd);
    $display("absent test done");
    issue(2'h0, codes[3], 36'h00000000f);
    await("plotter control", 7, 36'h00f);
    init_req = 1'b1;
    cyc(1);
    init_req = 1'b0;
    await("init control", 7, 36'h0);
    await("init buffer", 0, 36'h0);
    $display("initialize test done");
    conclude();
  end
endmodule : io_bus_device_select_and_strobes_tb
